// File: bench/bcc_plant.sv
// Far-side model: strap wiring and the two free-running clock sources
`timescale 1ns/1ns
module bcc_plant (
    input  wire  one_cell_i, // Inductor fitted when high
    output logic strap_o,    // Cell-mode strap level
    output logic osc_clk_o,  // Internal oscillator, 800 ns
    output logic sys_clk_o   // System clock, 600 ns
);
    // Inductor to battery reads high, short to ground reads low
    assign strap_o = one_cell_i;

    // Odd offsets keep the edges clear of the block clock edges
    initial begin
        osc_clk_o = 1'b0;
        #13;
        forever #400 osc_clk_o = ~osc_clk_o;
    end
    initial begin
        sys_clk_o = 1'b0;
        #7;
        // Held fixed: software only ever trims this source downward
        forever #300 sys_clk_o = ~sys_clk_o;
    end
endmodule

// File: bench/bcc_props.sv
// Port checker for the boost converter control block
`timescale 1ns/1ns
module bcc_props (
    input wire mclk_i,            // Block clock
    input wire rst_n_i,           // Power-on reset
    input wire sleep_i,           // Sleep level
    input wire hresp_o,           // Bus response
    input wire conv_clk_o,        // Switching clock
    input wire switch_drive_o,    // Switch drive
    input wire pulse_skipped_o,   // Skip pulse
    input wire conv_enable_o,     // Converter enable
    input wire out_tie_battery_o, // Output tied to battery
    input wire one_cell_mode_o    // Latched cell mode
);
    // ==========================================================
    // Assertions, all in the block clock domain
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_TWO_CELL: assert property (
        !one_cell_mode_o |-> !conv_enable_o)
        else $error("converter enabled in two-cell mode");
    AST_SLEEP_OFF: assert property (sleep_i |=> !conv_enable_o)
        else $error("converter enabled in sleep");
    AST_AWAKE_ON: assert property (
        one_cell_mode_o && !sleep_i |=> conv_enable_o)
        else $error("converter off while awake");
    AST_CELL_HOLD: assert property (one_cell_mode_o |=> one_cell_mode_o)
        else $error("cell mode changed outside reset");
    AST_TIE_SLEEP: assert property (
        out_tie_battery_o |-> $past(sleep_i) && !conv_enable_o)
        else $error("output tied outside sleep");
    // A skip shows the clock high with no drive, for one cycle only
    AST_SKIP_ONE: assert property (
        pulse_skipped_o |-> conv_clk_o && !switch_drive_o
        ##1 !pulse_skipped_o)
        else $error("bad skip pulse");
    AST_DRIVE_HIGH: assert property (switch_drive_o |-> conv_clk_o)
        else $error("drive outside high phase");
    // Runts would be single-cycle phases
    AST_NO_RUNT_HI: assert property ($rose(conv_clk_o) |=> conv_clk_o)
        else $error("runt high phase");
    AST_NO_RUNT_LO: assert property (
        $fell(conv_clk_o) |=> !conv_clk_o)
        else $error("runt low phase");
    AST_OKAY: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");

    C_SKIP: cover property (pulse_skipped_o);
    C_EN: cover property ($rose(conv_enable_o));
    C_TIE: cover property ($rose(out_tie_battery_o));
endmodule

bind bcc_top bcc_props u_props (.mclk_i, .rst_n_i, .sleep_i, .hresp_o,
    .conv_clk_o, .switch_drive_o, .pulse_skipped_o, .conv_enable_o,
    .out_tie_battery_o, .one_cell_mode_o);

// File: bench/boost_converter_control_tb_top.sv
// Testbench for the boost converter control block
`timescale 1ns/1ns
module boost_converter_control_tb_top;
    logic        mclk_i = 0;
    logic        rst_n_i = 0;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic [7:0]  haddr = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] rd;
    logic        sleep = 0;
    logic        one_cell = 1;
    logic [9:0]  on_time = 10'h3ff;
    wire  [31:0] hrdata;
    wire         hready, strap, osc, sysc, cclk, skp, en, tie, onec, sync;
    wire  [2:0]  vsel;
    wire         swsz, ilim, drv;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          p, n, dr;
    int          mins[4] = '{0, 20, 40, 80};

    always #25 mclk_i = ~mclk_i;

    bcc_plant u_plant (.one_cell_i(one_cell), .strap_o(strap),
        .osc_clk_o(osc), .sys_clk_o(sysc));

    bcc_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .cell_mode_strap_pin_i(strap), .sleep_i(sleep), .osc_clk_i(osc),
        .sys_clk_i(sysc), .on_time_ns_i(on_time), .conv_clk_o(cclk),
        .switch_drive_o(drv), .pulse_skipped_o(skp), .conv_enable_o(en),
        .out_tie_battery_o(tie), .one_cell_mode_o(onec),
        .out_voltage_sel_o(vsel), .switch_size_select_o(swsz),
        .current_limit_select_o(ilim), .adc_sync_enable_o(sync));

    // ==========================================================
    // Checking and closing
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task end_sim;
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the under two thousand cycles the run needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim;
        end
    end

    // ==========================================================
    // Bus and timing helpers, all entered just after a rising edge
    task rdy;
        do @(posedge mclk_i); while (hready !== 1'b1);
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        rd = hrdata;
    endtask

    task rck(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task rise;
        while (cclk !== 1'b0) @(posedge mclk_i);
        while (cclk !== 1'b1) @(posedge mclk_i);
    endtask

    // Skip the start consumed by a settings change before measuring
    task per(output int q);
        rise;
        rise;
        rise;
        q = 0;
        while (cclk !== 1'b0) begin @(posedge mclk_i); q++; end
        while (cclk !== 1'b1) begin @(posedge mclk_i); q++; end
    endtask

    // Counts skip pulses and switch drive cycles over three periods
    task skips(output int q, output int r);
        repeat (20) @(posedge mclk_i);
        q = 0;
        r = 0;
        repeat (48) begin
            @(posedge mclk_i);
            if (skp === 1'b1) q++;
            if (drv === 1'b1) r++;
        end
    endtask

    task do_reset;
        rst_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        do_reset;
        rck(8'h00, 32'h21);
        rck(8'h04, 32'h0);
        rck(8'h0c, 32'h0);
        chk({ilim, swsz, vsel}, 5'h09);
        chk(onec, 1);
        chk(en, 1);
        rck(8'h08, 32'h03);
        ahb(1'b1, 8'h04, 32'hff);
        rck(8'h04, 32'h6f);
        chk(ilim, 1);
        ahb(1'b1, 8'h04, 32'h0);
        // Sleep: converter off, output tied unless float is set
        sleep <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(en, 0);
        chk(tie, 1);
        ahb(1'b1, 8'h04, 32'h02);
        repeat (2) @(posedge mclk_i);
        chk(tie, 0);
        ahb(1'b1, 8'h04, 32'h0);
        repeat (2) @(posedge mclk_i);
        chk(tie, 1);
        sleep <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk(en, 1);
        chk(tie, 0);
        // Oscillator ignores the divider; system path divides 1..8
        ahb(1'b1, 8'h04, 32'h60);
        per(p);
        chk(p, 16);
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, 8'h04, 32'h01 | (c << 5));
            per(p);
            chk(p, 12 << c);
        end
        ahb(1'b1, 8'h04, 32'h01);
        per(p);
        chk(sysc, 1);
        ahb(1'b1, 8'h04, 32'h09);
        per(p);
        chk(sysc, 0);
        ahb(1'b1, 8'h04, 32'h0);
        // Skip just below each minimum, none at it
        for (int c = 1; c < 4; c++) begin
            ahb(1'b1, 8'h00, 32'h29 | (c << 6));
            on_time <= 10'(mins[c] - 1);
            skips(n, dr);
            chk(n > 0, 1);
            chk(dr, 0);
            on_time <= 10'(mins[c]);
            skips(n, dr);
            chk(n > 0, 0);
            chk(dr > 0, 1);
        end
        chk(sync, 1);
        ahb(1'b1, 8'h00, 32'h29);
        on_time <= 10'h0;
        skips(n, dr);
        chk(n > 0, 0);
        chk(dr > 0, 1);
        rck(8'h08, 32'h0b);
        ahb(1'b1, 8'h08, 32'h08);
        rck(8'h08, 32'h03);
        ahb(1'b1, 8'h00, 32'h07);
        @(posedge mclk_i);
        chk({swsz, vsel}, 4'h7);
        // Strap moves at runtime, then a power-on reset into two-cell
        one_cell <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk(onec, 1);
        do_reset;
        chk(onec, 0);
        chk(en, 0);
        rck(8'h08, 32'h0);
        end_sim;
    end
endmodule

// File: core/bcc_defines.vh
// Constants for the boost converter control block
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH

// ============================================================
// Register byte offsets
`define BCC_CTRL_OFS        8'h00
`define BCC_CFG_OFS         8'h04
`define BCC_STAT_OFS        8'h08

// ============================================================
// Reset values
`define BCC_CTRL_RST        8'h21
`define BCC_CFG_RST         8'h00

// ============================================================
// Control register fields
`define BCC_CTRL_MINPUL_HI  7
`define BCC_CTRL_MINPUL_LO  6
`define BCC_CTRL_SWSIZE     5
`define BCC_CTRL_ADCSYNC    3
`define BCC_CTRL_VSEL_HI    2
`define BCC_CTRL_VSEL_LO    0
`define BCC_CTRL_WMASK      8'hef

// ============================================================
// Configuration register fields
`define BCC_CFG_DIV_HI      6
`define BCC_CFG_DIV_LO      5
`define BCC_CFG_INV         3
`define BCC_CFG_ILIM        2
`define BCC_CFG_FLOAT       1
`define BCC_CFG_SRC         0
`define BCC_CFG_WMASK       8'h6f

// ============================================================
// Status register fields
`define BCC_STAT_ONECELL    0
`define BCC_STAT_ENABLE     1
`define BCC_STAT_TIE        2
`define BCC_STAT_SKIP       3
`define BCC_STAT_SRC        4

// ============================================================
// Minimum pulse widths in ns for codes 01, 10, 11
`define BCC_MINPUL_1_NS     10'd20
`define BCC_MINPUL_2_NS     10'd40
`define BCC_MINPUL_3_NS     10'd80

`endif

// File: core/bcc_top.v
// Boost converter control: strap latch, enable, clocking, pulse skip, sleep
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "bcc_defines.vh"

// Behaviour
// - Latch one- or two-cell from the strap at power-on reset.
// - Two-cell mode keeps the converter enable inactive for good.
// - One-cell mode: converter off in sleep, on in every other mode.
// - The latched cell mode changes only during power-on reset and at the strap capture just after its release.
// - On-time below the programmed minimum skips the whole switching pulse.
// - Source select: 0 internal oscillator, 1 system clock path.
// - System clock path goes through a programmable divider.
// - Invert bit set inverts the system clock ahead of the divider.
// - Sleep of a one-cell part, converter off, ties the output node to the battery.
// - Sleep-float bit set leaves the output node floating in sleep.
// - Divide field codes 00..11 divide by 1, 2, 4, 8.
// - Divide field is ignored when clocked from the internal oscillator.
// - Minimum pulse codes: none, 20 ns, 40 ns, 80 ns.
module bcc_top (
    input  wire        mclk_i,            // 20 MHz block clock
    input  wire        rst_n_i,           // Power-on reset, sync, active low
    input  wire        hsel_i,            // AHB select
    input  wire [7:0]  haddr_i,           // AHB byte address
    input  wire [1:0]  htrans_i,          // AHB transfer type
    input  wire        hwrite_i,          // AHB write
    input  wire [2:0]  hsize_i,           // AHB size, word only
    input  wire [31:0] hwdata_i,          // AHB write data
    input  wire        hready_i,          // AHB bus ready
    output wire [31:0] hrdata_o,          // AHB read data
    output wire        hreadyout_o,       // AHB slave ready
    output wire        hresp_o,           // AHB response, always OKAY
    input  wire        cell_mode_strap_pin_i, // High: one-cell strap
    input  wire        sleep_i,           // Power manager sleep level
    input  wire        osc_clk_i,         // Internal converter oscillator
    input  wire        sys_clk_i,         // System clock for the divider
    input  wire [9:0]  on_time_ns_i,      // Loop's requested on-time, ns
    output wire        conv_clk_o,        // Switching clock
    output wire        switch_drive_o,    // Duty switch drive
    output wire        pulse_skipped_o,   // One-cycle pulse per skip
    output wire        conv_enable_o,     // Converter enable
    output wire        out_tie_battery_o, // Output node tied to battery
    output wire        one_cell_mode_o,   // Latched cell mode
    output wire [2:0]  out_voltage_sel_o, // Target voltage code
    output wire        switch_size_select_o,   // Small switches when set
    output wire        current_limit_select_o, // Peak current select
    output wire        adc_sync_enable_o  // ADC sync to converter
);

    // ============================================================
    // Registers
    reg  [7:0]  ctrl_reg;
    reg  [7:0]  cfg_reg;
    reg         skip_sticky_reg;
    reg  [31:0] hrdata_reg;
    reg         hreadyout_reg;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [2:0]  strap_sync_reg;
    reg  [2:0]  osc_sync_reg;
    reg  [2:0]  sys_sync_reg;
    reg  [1:0]  strap_wait_reg;
    reg         strap_done_reg;
    reg         one_cell_reg;
    reg         conv_enable_reg;
    reg         tie_reg;
    reg         app_src_reg;
    reg  [1:0]  app_div_reg;
    reg         app_inv_reg;
    reg  [2:0]  div_cnt_reg;
    reg         conv_clk_reg;
    reg         drive_reg;
    reg         skipped_reg;

    wire        addr_phase;
    wire        w_ctrl;
    wire        w_cfg;
    wire        w_stat;
    wire [7:0]  stat_val;
    wire        osc_rise;
    wire        osc_fall;
    wire        sys_rise;
    wire        sys_fall;
    wire        sel_rise;
    wire        sel_fall;
    wire [2:0]  div_last;
    wire [2:0]  div_half;
    wire        tick;
    wire        fall_evt;
    wire        cfg_change;
    wire [9:0]  min_ns;
    wire        skip_now;

    // ============================================================
    // AHB-Lite slave: zero wait states, writes land in data phase
    assign addr_phase = hsel_i & htrans_i[1] & hready_i;
    assign w_ctrl = wr_pend_reg & (wr_addr_reg == `BCC_CTRL_OFS);
    assign w_cfg  = wr_pend_reg & (wr_addr_reg == `BCC_CFG_OFS);
    assign w_stat = wr_pend_reg & (wr_addr_reg == `BCC_STAT_OFS);

    // Status word shows the block's own live state
    assign stat_val = {3'h0, app_src_reg, skip_sticky_reg, tie_reg,
                       conv_enable_reg, one_cell_reg};

    // Address phase capture and read data, unmapped reads give zero
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            wr_pend_reg   <= addr_phase & hwrite_i;
            if (addr_phase) begin
                wr_addr_reg <= haddr_i;
            end
            if (addr_phase && !hwrite_i) begin
                case (haddr_i)
                    `BCC_CTRL_OFS: hrdata_reg <= {24'h000000, ctrl_reg};
                    `BCC_CFG_OFS:  hrdata_reg <= {24'h000000, cfg_reg};
                    `BCC_STAT_OFS: hrdata_reg <= {24'h000000, stat_val};
                    default:       hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software registers; reserved bits are masked so they read zero
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `BCC_CTRL_RST;
            cfg_reg  <= `BCC_CFG_RST;
        end else begin
            if (w_ctrl) begin
                ctrl_reg <= hwdata_i[7:0] & `BCC_CTRL_WMASK;
            end
            if (w_cfg) begin
                cfg_reg <= hwdata_i[7:0] & `BCC_CFG_WMASK;
            end
        end
    end

    // Sticky skip flag, write one to clear; a new skip wins over a clear
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            skip_sticky_reg <= 1'b0;
        end else if (skip_now) begin
            skip_sticky_reg <= 1'b1;
        end else if (w_stat && hwdata_i[`BCC_STAT_SKIP]) begin
            skip_sticky_reg <= 1'b0;
        end
    end

    // ============================================================
    // Pin synchronisers: three stages, only stages two and three are used
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            strap_sync_reg <= 3'h0;
            osc_sync_reg   <= 3'h0;
            sys_sync_reg   <= 3'h0;
        end else begin
            strap_sync_reg <= {strap_sync_reg[1:0], cell_mode_strap_pin_i};
            osc_sync_reg   <= {osc_sync_reg[1:0], osc_clk_i};
            sys_sync_reg   <= {sys_sync_reg[1:0], sys_clk_i};
        end
    end

    // ============================================================
    // Cell mode latch. The strap is taken after reset release once the
    // synchroniser holds real pin samples; only this reset clears it,
    // so nothing at run time can move it.
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            strap_wait_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            one_cell_reg   <= 1'b0;
        end else if (!strap_done_reg) begin
            if (strap_wait_reg != 2'h3) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end else if (strap_sync_reg[1] == strap_sync_reg[2]) begin
                strap_done_reg <= 1'b1;
                one_cell_reg   <= strap_sync_reg[2];
            end
        end
    end

    // ============================================================
    // Converter enable and sleep output behaviour
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            conv_enable_reg <= 1'b0;
            tie_reg         <= 1'b0;
        end else begin
            // Two-cell keeps it off whatever software sets
            conv_enable_reg <= one_cell_reg & ~sleep_i;
            // Tie only in sleep of a one-cell part, unless float is set
            tie_reg <= one_cell_reg & sleep_i
                       & ~cfg_reg[`BCC_CFG_FLOAT];
        end
    end

    // ============================================================
    // Switching clock. Edges come from the synchronised pins, so each
    // input must stay below a quarter of mclk for clean edge detection.
    assign osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];
    assign osc_fall = ~osc_sync_reg[1] & osc_sync_reg[2];
    assign sys_rise = sys_sync_reg[1] & ~sys_sync_reg[2];
    assign sys_fall = ~sys_sync_reg[1] & sys_sync_reg[2];

    // Inversion swaps the edges of the system clock before division
    assign sel_rise = app_inv_reg ? sys_fall : sys_rise;
    assign sel_fall = app_inv_reg ? sys_rise : sys_fall;

    // Divide by 1, 2, 4 or 8 for codes 00..11
    assign div_last = (3'h1 << app_div_reg) - 3'h1;
    assign div_half = (app_div_reg == 2'h0) ? 3'h0
                    : (3'h1 << (app_div_reg - 2'h1));

    // Period start and mid-period low edge; divider unused on oscillator
    assign tick = app_src_reg
                ? (sel_rise & (div_cnt_reg == 3'h0))
                : osc_rise;
    assign fall_evt = app_src_reg
                ? ((app_div_reg == 2'h0) ? sel_fall
                   : (sel_rise & (div_cnt_reg == div_half)))
                : osc_fall;

    assign cfg_change = (app_src_reg != cfg_reg[`BCC_CFG_SRC])
                      | (app_div_reg != cfg_reg[`BCC_CFG_DIV_HI:
                                                `BCC_CFG_DIV_LO])
                      | (app_inv_reg != cfg_reg[`BCC_CFG_INV]);

    // Minimum pulse width per code, zero means no minimum
    assign min_ns = (ctrl_reg[`BCC_CTRL_MINPUL_HI:`BCC_CTRL_MINPUL_LO]
                     == 2'h1) ? `BCC_MINPUL_1_NS
                  : (ctrl_reg[`BCC_CTRL_MINPUL_HI:`BCC_CTRL_MINPUL_LO]
                     == 2'h2) ? `BCC_MINPUL_2_NS
                  : (ctrl_reg[`BCC_CTRL_MINPUL_HI:`BCC_CTRL_MINPUL_LO]
                     == 2'h3) ? `BCC_MINPUL_3_NS
                  : 10'd0;

    // A pulse is skipped whole rather than emitted narrow
    assign skip_now = tick & ~cfg_change & conv_enable_reg
                    & (on_time_ns_i < min_ns);

    // Clock settings are applied only at a period start while the
    // clock is low; the clock then waits low for the new source, so a
    // change stretches one low phase instead of cutting a pulse.
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            app_src_reg  <= 1'b0;
            app_div_reg  <= 2'h0;
            app_inv_reg  <= 1'b0;
            div_cnt_reg  <= 3'h0;
            conv_clk_reg <= 1'b0;
        end else if (tick && cfg_change) begin
            app_src_reg  <= cfg_reg[`BCC_CFG_SRC];
            app_div_reg  <= cfg_reg[`BCC_CFG_DIV_HI:`BCC_CFG_DIV_LO];
            app_inv_reg  <= cfg_reg[`BCC_CFG_INV];
            div_cnt_reg  <= 3'h0;
            conv_clk_reg <= 1'b0;
        end else begin
            if (app_src_reg && sel_rise) begin
                div_cnt_reg <= (div_cnt_reg == div_last) ? 3'h0
                             : div_cnt_reg + 3'h1;
            end
            if (tick) begin
                conv_clk_reg <= 1'b1;
            end else if (fall_evt) begin
                conv_clk_reg <= 1'b0;
            end
        end
    end

    // Switch drive follows the clock's high phase unless skipped or off
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            drive_reg   <= 1'b0;
            skipped_reg <= 1'b0;
        end else begin
            skipped_reg <= skip_now;
            if (!conv_enable_reg) begin
                drive_reg <= 1'b0;
            end else if (tick && !cfg_change) begin
                drive_reg <= ~skip_now;
            end else if (fall_evt) begin
                drive_reg <= 1'b0;
            end
        end
    end

    // ============================================================
    // Outputs, all straight from flip-flops except hresp_o, tied to zero
    assign hrdata_o               = hrdata_reg;
    assign hreadyout_o            = hreadyout_reg;
    assign hresp_o                = 1'b0;
    assign conv_clk_o             = conv_clk_reg;
    assign switch_drive_o         = drive_reg;
    assign pulse_skipped_o        = skipped_reg;
    assign conv_enable_o          = conv_enable_reg;
    assign out_tie_battery_o      = tie_reg;
    assign one_cell_mode_o        = one_cell_reg;
    assign out_voltage_sel_o      = ctrl_reg[`BCC_CTRL_VSEL_HI:
                                             `BCC_CTRL_VSEL_LO];
    assign switch_size_select_o   = ctrl_reg[`BCC_CTRL_SWSIZE];
    assign current_limit_select_o = cfg_reg[`BCC_CFG_ILIM];
    // Software is expected to set this bit when the ADC runs
    assign adc_sync_enable_o      = ctrl_reg[`BCC_CTRL_ADCSYNC];

endmodule
